/* core/uoc_top.sv */
// USB OTG control/status block: APB register file, DMA request gating,
// role and speed reporting, VBUS level coding, host negotiation and interrupts.
// Assumes link status inputs are synchronous to core_clk_i.
// Functional notes
// (R1) Packet size field gives 8 bytes times two to the code; codes above 1001 reserved.
// (R2) Size limit counts whole packets before any FIFO splitting.
// (R3) Tx early bit set drops IN DMA request at max minus 8 bytes.
// (R4) Rx early bit set drops OUT DMA request at max minus 8 bytes.
// (R5) Role bit reads 1 as B device, 0 as A device.
// (R6) In host mode, full/high-speed detect bit reads 1 when such a device attached.
// (R7) In host mode, low-speed detect bit reads 1 when such a device attached.
// (R8) Bus level field: 11 valid, 10 A-valid, 00 below session end.
// (R9) Level between session end and A-valid reads 01.
// (R10) Host bit reads 1 while acting as host.
// (R11) B device: request bit starts negotiation at suspend; hardware clears when done.
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`default_nettype none
module uoc_top
  import uoc_pkg::*;
#(
  parameter int CNT_W = 13
)
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic b_role_i,
  input wire logic acting_as_host_i,
  input wire logic conn_fs_hs_i,
  input wire logic conn_ls_i,
  input wire logic vbus_valid_i,
  input wire logic vbus_avalid_i,
  input wire logic vbus_sess_i,
  input wire logic suspend_i,
  input wire logic neg_done_i,
  input wire logic tx_pkt_start_i,
  input wire logic tx_wr_i,
  input wire logic rx_pkt_start_i,
  input wire logic rx_wr_i,
  output logic tx_dma_req_o,
  output logic rx_dma_req_o,
  output logic neg_start_o,
  output logic [CNT_W-1:0] max_packet_bytes_o,
  output logic irq_o
);
  initial
  begin
    if (CNT_W != 13)
    begin
      $error("CNT_W must be 13 to hold 4096");
    end
  end

  typedef struct packed {
    logic [UOC_TXSZ_W-1:0] tx_fifo_packet_size;
    logic tx_early_dma_select;
    logic rx_early_dma_select;
    logic [UOC_IRQ_W-1:0] irq_stat;
    logic [UOC_IRQ_W-1:0] irq_mask;
    logic [1:0] vbus_prev;
    logic role_prev;
    logic conn_prev;
    logic [31:0] rdata;
    logic [12:0] max_bytes;
  } uoc_state_t;

  uoc_state_t s_q;
  uoc_state_t s_d;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic hreq_set;
  logic hreq_clr;
  logic negotiation_request;
  logic neg_done;
  logic [1:0] vbus_lvl;
  logic full_high_speed_detected;
  logic low_speed_detected;
  logic [UOC_IRQ_W-1:0] ev;
  logic [31:0] ctrl_word;

  // Size code to bytes; reserved codes clamp to the largest legal size.
  function automatic logic [12:0] size_bytes(input logic [3:0] code);
    logic [3:0] c;
    c = (code > UOC_TXSZ_MAX_CODE) ? UOC_TXSZ_MAX_CODE : code;
    return 13'(UOC_BASE_PKT_BYTES << c); // (R1) (R2)
  endfunction : size_bytes

  // Comparator inputs are treated as nested thresholds.
  function automatic logic [1:0] vbus_code(input logic v, input logic a, input logic s);
    if (v)
    begin
      return UOC_VBUS_VALID; // (R8)
    end
    else if (a)
    begin
      return UOC_VBUS_AVALID; // (R8)
    end
    else if (s)
    begin
      return UOC_VBUS_SESS; // (R9)
    end
    return UOC_VBUS_BELOW; // (R8)
  endfunction : vbus_code

  assign addr_ok = (paddr == UOC_OFF_CTRL) || (paddr == UOC_OFF_IRQ_STAT) ||
                   (paddr == UOC_OFF_IRQ_MASK) || (paddr == UOC_OFF_DMA_CFG);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign hreq_set = wr_acc && (paddr == UOC_OFF_CTRL) && pwdata[UOC_HREQ_BIT];
  assign hreq_clr = wr_acc && (paddr == UOC_OFF_CTRL) && !pwdata[UOC_HREQ_BIT];
  assign vbus_lvl = vbus_code(vbus_valid_i, vbus_avalid_i, vbus_sess_i);
  assign full_high_speed_detected = acting_as_host_i && conn_fs_hs_i; // (R6)
  assign low_speed_detected = acting_as_host_i && conn_ls_i; // (R7)

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[UOC_TXSZ_LSB +: UOC_TXSZ_W] = s_q.tx_fifo_packet_size;
    ctrl_word[UOC_TX_EARLY_BIT] = s_q.tx_early_dma_select;
    ctrl_word[UOC_RX_EARLY_BIT] = s_q.rx_early_dma_select;
    ctrl_word[UOC_B_ROLE_BIT] = b_role_i; // (R5)
    ctrl_word[UOC_FS_HS_BIT] = full_high_speed_detected;
    ctrl_word[UOC_LS_BIT] = low_speed_detected;
    ctrl_word[UOC_VBUS_LSB +: 2] = vbus_lvl;
    ctrl_word[UOC_HOST_BIT] = acting_as_host_i; // (R10)
    ctrl_word[UOC_HREQ_BIT] = negotiation_request; // (R11)
  end

  always_comb
  begin
    ev = '0;
    ev[UOC_IRQ_CONN] = (conn_fs_hs_i || conn_ls_i) && !s_q.conn_prev;
    ev[UOC_IRQ_NEGDONE] = neg_done;
    ev[UOC_IRQ_VBUS] = (vbus_lvl != s_q.vbus_prev);
    ev[UOC_IRQ_ROLE] = (b_role_i != s_q.role_prev);
    s_d = s_q;
    s_d.vbus_prev = vbus_lvl;
    s_d.role_prev = b_role_i;
    s_d.conn_prev = conn_fs_hs_i || conn_ls_i;
    s_d.max_bytes = size_bytes(s_q.tx_fifo_packet_size);
    if (wr_acc)
    begin
      case (paddr)
        UOC_OFF_CTRL:
        begin
          s_d.tx_fifo_packet_size = pwdata[UOC_TXSZ_LSB +: UOC_TXSZ_W];
          s_d.tx_early_dma_select = pwdata[UOC_TX_EARLY_BIT];
          s_d.rx_early_dma_select = pwdata[UOC_RX_EARLY_BIT];
        end
        UOC_OFF_IRQ_STAT:
        begin
          s_d.irq_stat = s_q.irq_stat & ~pwdata[UOC_IRQ_W-1:0];
        end
        UOC_OFF_IRQ_MASK:
        begin
          s_d.irq_mask = pwdata[UOC_IRQ_W-1:0];
        end
        default:
        begin
          s_d.irq_mask = s_q.irq_mask;
        end
      endcase
    end
    // New events win over a write-one-to-clear in the same cycle.
    s_d.irq_stat = s_d.irq_stat | ev;
    if (rd_acc)
    begin
      case (paddr)
        UOC_OFF_CTRL: s_d.rdata = ctrl_word;
        UOC_OFF_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
        UOC_OFF_IRQ_MASK: s_d.rdata = 32'(s_q.irq_mask);
        UOC_OFF_DMA_CFG: s_d.rdata = 32'(s_q.max_bytes);
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '{tx_fifo_packet_size: UOC_TXSZ_RESET, max_bytes: UOC_BASE_PKT_BYTES,
               default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  uoc_negotiate u_neg (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .req_set_i(hreq_set),
    .req_clr_i(hreq_clr),
    .b_role_i(b_role_i),
    .suspend_i(suspend_i),
    .done_i(neg_done_i),
    .req_o(negotiation_request),
    .start_o(neg_start_o),
    .done_o(neg_done)
  );

  uoc_dma_req u_tx (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .start_i(tx_pkt_start_i),
    .wr_i(tx_wr_i),
    .max_bytes_i(s_q.max_bytes),
    .early_i(s_q.tx_early_dma_select),
    .req_o(tx_dma_req_o)
  );

  uoc_dma_req u_rx (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .start_i(rx_pkt_start_i),
    .wr_i(rx_wr_i),
    .max_bytes_i(s_q.max_bytes),
    .early_i(s_q.rx_early_dma_select),
    .req_o(rx_dma_req_o)
  );

  assign prdata = s_q.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign max_packet_bytes_o = s_q.max_bytes;
  assign irq_o = |(s_q.irq_stat & s_q.irq_mask);
endmodule : uoc_top
`default_nettype wire

/* core/uoc_pkg.sv */
// Package for the USB OTG control/status block: register map, fields, constants.
// Assumes a 32-bit APB register bus and a single 125 MHz core clock.
`default_nettype none
package uoc_pkg;
  // Register byte offsets.
  localparam logic [7:0] UOC_OFF_CTRL = 8'h00;
  localparam logic [7:0] UOC_OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0] UOC_OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] UOC_OFF_DMA_CFG = 8'h0C;
  // Control/status field positions.
  localparam int UOC_TXSZ_LSB = 16;
  localparam int UOC_TXSZ_W = 4;
  localparam int UOC_TX_EARLY_BIT = 9;
  localparam int UOC_RX_EARLY_BIT = 8;
  localparam int UOC_B_ROLE_BIT = 7;
  localparam int UOC_FS_HS_BIT = 6;
  localparam int UOC_LS_BIT = 5;
  localparam int UOC_VBUS_LSB = 3;
  localparam int UOC_HOST_BIT = 2;
  localparam int UOC_HREQ_BIT = 1;
  // Packet size codes.
  localparam logic [3:0] UOC_TXSZ_MAX_CODE = 4'h9;
  localparam logic [3:0] UOC_TXSZ_RESET = 4'h0;
  localparam logic [12:0] UOC_BASE_PKT_BYTES = 13'h0008;
  localparam logic [12:0] UOC_EARLY_MARGIN = 13'h0008;
  // Bus level codes.
  localparam logic [1:0] UOC_VBUS_VALID = 2'h3;
  localparam logic [1:0] UOC_VBUS_AVALID = 2'h2;
  localparam logic [1:0] UOC_VBUS_SESS = 2'h1;
  localparam logic [1:0] UOC_VBUS_BELOW = 2'h0;
  // Interrupt status bit positions.
  localparam int UOC_IRQ_CONN = 0;
  localparam int UOC_IRQ_NEGDONE = 1;
  localparam int UOC_IRQ_VBUS = 2;
  localparam int UOC_IRQ_ROLE = 3;
  localparam int UOC_IRQ_W = 4;
  typedef enum logic [1:0] {
    UOC_NEG_IDLE,
    UOC_NEG_ARMED,
    UOC_NEG_RUN
  } uoc_neg_t;
endpackage : uoc_pkg
`default_nettype wire

/* core/uoc_dma_req.sv */
// DMA request gate for one endpoint direction: asserts while a packet is being
// filled and drops at max packet size or at max packet size minus 8 bytes.
// Assumes the byte count is cleared by the packet start strobe.
`default_nettype none
module uoc_dma_req
  import uoc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic wr_i,
  input wire logic [12:0] max_bytes_i,
  input wire logic early_i,
  output logic req_o
);
  typedef struct packed {
    logic [12:0] cnt;
    logic busy;
  } uoc_dreq_t;

  uoc_dreq_t s_q;
  uoc_dreq_t s_d;
  logic [12:0] limit;

  always_comb
  begin
    // Early mode drops the request 8 bytes ahead so DMA latency cannot overfill.
    limit = early_i ? (max_bytes_i - UOC_EARLY_MARGIN) : max_bytes_i; // (R3) (R4)
    s_d = s_q;
    if (start_i)
    begin
      s_d.cnt = '0;
      s_d.busy = 1'b1;
    end
    else if (wr_i && s_q.busy)
    begin
      s_d.cnt = 13'(s_q.cnt + 13'h0004);
    end
    if (!start_i && (s_d.cnt >= limit))
    begin
      s_d.busy = 1'b0; // (R3) (R4)
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign req_o = s_q.busy;
endmodule : uoc_dma_req
`default_nettype wire

/* core/uoc_negotiate.sv */
// Host negotiation sequencer for the B-device role.
// Assumes the PHY side reports suspend entry and negotiation completion as levels/pulses.
`default_nettype none
module uoc_negotiate
  import uoc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic req_set_i,
  input wire logic req_clr_i,
  input wire logic b_role_i,
  input wire logic suspend_i,
  input wire logic done_i,
  output logic req_o,
  output logic start_o,
  output logic done_o
);
  typedef struct packed {
    uoc_neg_t st;
    logic start;
    logic done;
  } uoc_negs_t;

  uoc_negs_t s_q;
  uoc_negs_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.done = 1'b0;
    case (s_q.st)
      UOC_NEG_IDLE:
      begin
        if (req_set_i && b_role_i)
        begin
          s_d.st = UOC_NEG_ARMED; // (R11)
        end
      end
      UOC_NEG_ARMED:
      begin
        if (req_clr_i || !b_role_i)
        begin
          s_d.st = UOC_NEG_IDLE;
        end
        else if (suspend_i)
        begin
          s_d.st = UOC_NEG_RUN; // (R11)
          s_d.start = 1'b1;
        end
      end
      UOC_NEG_RUN:
      begin
        if (done_i)
        begin
          s_d.st = UOC_NEG_IDLE; // (R11)
          s_d.done = 1'b1;
        end
      end
      default:
      begin
        s_d.st = UOC_NEG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_q <= '{st: UOC_NEG_IDLE, start: 1'b0, done: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign req_o = (s_q.st != UOC_NEG_IDLE);
  assign start_o = s_q.start;
  assign done_o = s_q.done;
endmodule : uoc_negotiate
`default_nettype wire

/* verif/uoc_top_sva.sv */
// Assertions on the ports of the USB OTG control/status block.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none
module uoc_top_sva
#(
  parameter int CNT_W = 13
)
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic suspend_i,
  input wire logic tx_pkt_start_i,
  input wire logic tx_wr_i,
  input wire logic rx_wr_i,
  input wire logic rx_pkt_start_i,
  input wire logic tx_dma_req_o,
  input wire logic rx_dma_req_o,
  input wire logic neg_start_o,
  input wire logic [CNT_W-1:0] max_packet_bytes_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence s_acc;
    psel && penable;
  endsequence
  // Two quiet cycles are needed because the drop may lag the last counted word by one.
  sequence s_tx_quiet;
    tx_dma_req_o && !tx_wr_i && !$past(tx_wr_i) && !tx_pkt_start_i;
  endsequence
  sequence s_rx_quiet;
    rx_dma_req_o && !rx_wr_i && !$past(rx_wr_i) && !rx_pkt_start_i;
  endsequence
  a_apb_zero_wait: assert property (s_acc |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (s_acc and paddr > 8'h0C |-> pslverr)
    else $error("no error on unmapped access");
  a_size_legal: assert property ($onehot(max_packet_bytes_o) && max_packet_bytes_o >= 8
    && max_packet_bytes_o <= 4096) else $error("max packet bytes illegal");
  a_tx_req_start: assert property (tx_pkt_start_i && max_packet_bytes_o > 8 |=> tx_dma_req_o)
    else $error("tx request not raised");
  a_tx_req_hold: assert property (s_tx_quiet |=> tx_dma_req_o)
    else $error("tx request dropped without data");
  a_rx_req_hold: assert property (s_rx_quiet |=> rx_dma_req_o)
    else $error("rx request dropped without data");
  a_neg_one_pulse: assert property (neg_start_o |=> !neg_start_o)
    else $error("negotiation start longer than one cycle");
  a_neg_on_suspend: assert property (neg_start_o |-> $past(suspend_i))
    else $error("negotiation start without suspend");
endmodule : uoc_top_sva
bind uoc_top uoc_top_sva #(.CNT_W(CNT_W)) u_sva (.core_clk_i, .resetn_i, .psel, .penable,
  .paddr, .pready, .pslverr, .suspend_i, .tx_pkt_start_i, .tx_wr_i, .rx_wr_i, .rx_pkt_start_i,
  .tx_dma_req_o, .rx_dma_req_o, .neg_start_o, .max_packet_bytes_o);
`default_nettype wire

/* verif/uoc_peer.sv */
// Peer model: endpoint DMA writer and far end of host negotiation.
// Assumes request levels are synchronous to core_clk_i.
`default_nettype none
module uoc_peer
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire logic tx_req_i,
  input wire logic rx_req_i,
  input wire logic neg_start_i,
  output logic tx_wr_o,
  output logic rx_wr_o,
  output logic neg_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tx_gap_q, rx_gap_q, neg_q;
  // Slow mode idles two cycles per word, so no word is in flight when a request drops.
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i)
    begin
      {tx_wr_o, rx_wr_o, neg_done_o, tx_gap_q, rx_gap_q, neg_q} <= '0;
    end
    else
    begin
      tx_wr_o <= tx_req_i && tx_gap_q == 0;
      tx_gap_q <= (tx_req_i && tx_gap_q == 0) ? {slow_i, 1'b0} : tx_gap_q - {1'b0, |tx_gap_q};
      rx_wr_o <= rx_req_i && rx_gap_q == 0;
      rx_gap_q <= (rx_req_i && rx_gap_q == 0) ? {slow_i, 1'b0} : rx_gap_q - {1'b0, |rx_gap_q};
      neg_q <= neg_start_i ? 2'h3 : neg_q - {1'b0, |neg_q};
      neg_done_o <= neg_q == 2'h1;
    end
endmodule : uoc_peer
`default_nettype wire

/* verif/test_usb_otg_control_status.sv */
// Bench for the USB OTG control/status block with an APB master and the peer model.
// Assumes zero-wait APB and the register offsets of uoc_pkg.
`default_nettype none
module test_usb_otg_control_status
  import uoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, resetn_i = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, err;
  logic b_role_i = 0, acting_as_host_i = 0, conn_fs_hs_i = 0, conn_ls_i = 0, suspend_i = 0;
  logic vbus_valid_i = 0, vbus_avalid_i = 0, vbus_sess_i = 0, tx_pkt_start_i = 0;
  logic rx_pkt_start_i = 0, tx_wr_i, rx_wr_i, neg_done_i, pready, pslverr;
  logic tx_dma_req_o, rx_dma_req_o, neg_start_o, irq_o;
  logic [7:0] paddr = 0;
  logic [12:0] max_packet_bytes_o;
  logic [31:0] pwdata = 0, prdata, rd, v, seed = 32'h415d_28c2;
  int fail_count = 0, checks_done = 0, ntx, nrx, n;
  uoc_top DUT (.core_clk_i, .resetn_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .b_role_i, .acting_as_host_i, .conn_fs_hs_i, .conn_ls_i, .vbus_valid_i,
    .vbus_avalid_i, .vbus_sess_i, .suspend_i, .neg_done_i, .tx_pkt_start_i, .tx_wr_i,
    .rx_pkt_start_i, .rx_wr_i, .tx_dma_req_o, .rx_dma_req_o, .neg_start_o, .max_packet_bytes_o,
    .irq_o);
  uoc_peer PEER (.core_clk_i, .resetn_i, .slow_i(slow), .tx_req_i(tx_dma_req_o),
    .rx_req_i(rx_dma_req_o), .neg_start_i(neg_start_o), .tx_wr_o(tx_wr_i), .rx_wr_o(rx_wr_i),
    .neg_done_o(neg_done_i));
  initial forever #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    ntx += tx_wr_i;
    nrx += rx_wr_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [12:0] exp_bytes(input logic [3:0] c);
    return c > 9 ? 13'h1000 : 13'h0008 << c;
  endfunction : exp_bytes
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1;
    do @(posedge core_clk_i); while (pready !== 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic dma(input logic [3:0] c, input logic e, sl);
    logic [12:0] lim;
    lim = exp_bytes(c) - {e, 3'h0};
    apb(1, UOC_OFF_CTRL, {12'h0, c, 6'h0, e, e, 8'h0});
    slow <= sl;
    ntx = 0;
    nrx = 0;
    tx_pkt_start_i <= 1;
    rx_pkt_start_i <= 1;
    @(posedge core_clk_i);
    tx_pkt_start_i <= 0;
    rx_pkt_start_i <= 0;
    n = 0;
    do @(posedge core_clk_i); while ((tx_dma_req_o | rx_dma_req_o) && n++ < 5000);
    repeat (4) @(posedge core_clk_i);
    chk(ntx * 4 >= lim && ntx * 4 <= lim + (sl ? 0 : 8), 1);
    chk(nrx * 4 >= lim && nrx * 4 <= lim + (sl ? 0 : 8), 1);
  endtask : dma
  initial
  begin
    #400_000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1;
    apb(0, UOC_OFF_DMA_CFG, 0);
    chk(rd, 32'h0000_0008);
    for (int c = 0; c < 16; c++)
    begin
      apb(1, UOC_OFF_CTRL, c << 16);
      apb(0, UOC_OFF_DMA_CFG, 0);
      chk(rd, exp_bytes(4'(c)));
      chk(max_packet_bytes_o, exp_bytes(4'(c)));
    end
    dma(4'h1, 1, 1);
    dma(4'h2, 0, 1);
    dma(4'h9, 0, 1);
    repeat (6)
    begin
      v = xs();
      dma(4'(v[3:0] % 6 + 1), v[4], v[5]);
    end
    $display("Test dma done");
    repeat (16)
    begin
      v = xs();
      b_role_i <= v[0];
      acting_as_host_i <= v[1];
      conn_fs_hs_i <= v[2];
      conn_ls_i <= v[3];
      vbus_valid_i <= v[5:4] == 3;
      vbus_avalid_i <= v[5];
      vbus_sess_i <= |v[5:4];
      repeat (3) @(posedge core_clk_i);
      apb(0, UOC_OFF_CTRL, 0);
      chk(rd[7:2], {v[0], v[1] & v[2], v[1] & v[3], v[5:4], v[1]});
    end
    apb(1, UOC_OFF_IRQ_MASK, 0);
    apb(1, UOC_OFF_IRQ_STAT, 32'h0000_000F);
    b_role_i <= ~b_role_i;
    repeat (3) @(posedge core_clk_i);
    apb(0, UOC_OFF_IRQ_STAT, 0);
    chk(rd[3], 1);
    chk(irq_o, 0);
    apb(1, UOC_OFF_IRQ_MASK, 32'h0000_0008);
    @(posedge core_clk_i);
    chk(irq_o, 1);
    apb(1, UOC_OFF_IRQ_STAT, 32'h0000_0008);
    @(posedge core_clk_i);
    chk(irq_o, 0);
    $display("Test status done");
    b_role_i <= 1;
    apb(1, UOC_OFF_CTRL, 32'h0000_0002);
    apb(0, UOC_OFF_CTRL, 0);
    chk(rd[1], 1);
    suspend_i <= 1;
    n = 0;
    do @(posedge core_clk_i); while (neg_start_o !== 1 && n++ < 20);
    chk(neg_start_o, 1);
    suspend_i <= 0;
    repeat (8) @(posedge core_clk_i);
    apb(0, UOC_OFF_CTRL, 0);
    chk(rd[1], 0);
    apb(0, UOC_OFF_IRQ_STAT, 0);
    chk(rd[1], 1);
    apb(1, UOC_OFF_CTRL, 32'h0000_0002);
    apb(1, UOC_OFF_CTRL, 32'h0000_0000);
    apb(0, UOC_OFF_CTRL, 0);
    chk(rd[1], 0);
    b_role_i <= 0;
    apb(1, UOC_OFF_CTRL, 32'h0000_0002);
    apb(0, UOC_OFF_CTRL, 0);
    chk(rd[1], 0);
    apb(0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 32'h0000_0000);
    $display("Test negotiation done");
    complete_run();
  end
endmodule : test_usb_otg_control_status
`default_nettype wire
